// ===== crx_pkg.sv
// crx_pkg: register map, field positions and codes of the receive message handler.
// assumes a 32-bit plain register port with byte addresses on 6 address bits.
package crx_pkg;
	localparam int NOBJ = 32;
	// register byte addresses
	localparam logic [5:0] A_CTL = 6'h00;
	localparam logic [5:0] A_STS = 6'h04;
	localparam logic [5:0] A_INT = 6'h08;
	localparam logic [5:0] A_CRQ = 6'h0C;
	localparam logic [5:0] A_CMSK = 6'h10;
	localparam logic [5:0] A_MSK = 6'h14;
	localparam logic [5:0] A_ARB = 6'h18;
	localparam logic [5:0] A_MCTL = 6'h1C;
	localparam logic [5:0] A_DA = 6'h20;
	localparam logic [5:0] A_DB = 6'h24;
	localparam logic [5:0] A_PMAP = 6'h28;
	// control_reg bits
	localparam int CTL_IE = 1;
	localparam int CTL_SIE = 2;
	localparam int CTL_EIE = 3;
	// status_reg bits, last_error_code in [2:0]
	localparam int STS_TX_OK_FLAG = 3;
	localparam int STS_RX_OK_FLAG = 4;
	localparam int STS_WARN = 6;
	localparam int STS_BUS_OFF_FLAG = 7;
	// command_mask_reg bits
	localparam int CM_WRNRD = 7;
	localparam int CM_MASK = 6;
	localparam int CM_ARB = 5;
	localparam int CM_CTRL = 4;
	localparam int CM_CLRP = 3;
	localparam int CM_NDTR = 2;
	localparam int CM_DA = 1;
	localparam int CM_DB = 0;
	localparam logic [7:0] CMSK_RST = 8'h00;
	localparam logic [7:0] CMSK_READ_ALL = 8'h7F;
	// message_control_reg bits, data length in [3:0]
	localparam int MC_ND = 15;
	localparam int MC_ML = 14;
	localparam int MC_IP = 13;
	localparam int MC_UM = 12;
	localparam int MC_RXIE = 10;
	localparam int MC_TR = 8;
	localparam int MC_EOB = 7;
	// arbitration register bits, identifier in [28:0]
	localparam int ARB_VAL = 31;
	localparam int ARB_XTD = 30;
	// interrupt identifier codes
	localparam logic [15:0] ID_NONE = 16'h0000;
	localparam logic [15:0] ID_STATUS = 16'h8000;
endpackage

// ===== crx_prio_enc.sv
// crx_prio_enc: finds the lowest-numbered set request and returns its object number.
// assumes purely combinational use inside the message handler.
`timescale 1ns/100ps
module crx_prio_enc
	import crx_pkg::*;
(
	input wire logic [NOBJ-1:0] req,
	output logic [5:0] num
);
	// object 1 is bit 0 and wins; 0 means no request
	always_comb begin
		num = 6'h00;
		for (int i = NOBJ - 1; i >= 0; i--) begin
			if (req[i]) begin
				num = 6'(i + 1);
			end
		end
	end
endmodule

// ===== crx_handler.sv
// crx_handler: receive object storage, fifo chaining, remote requests, interrupt id.
// assumes the can core on the same clock gives one-cycle frame and status pulses.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - object storage stays consistent; cpu transfers never collide with message stores.
// - mask 0x7F then object number copies object, clears new data and pending.
// - stored identifier is the full received one, never the masked one.
// - new_data_flag tells whether a message arrived since the last read.
// - message_lost_flag set on overrun, only software clears it.
// - transmit_request_flag on a receive object sends a remote frame with its id.
// - matching data frame before the remote goes out clears transmit_request_flag.
// - fifo is matching objects, lowest first; only the last has end_of_buffer_flag.
// - fifo messages go to lowest free object, which gets new_data_flag.
// - object with new data and no end of buffer is locked against message stores.
// - with no earlier entry released, the last fifo object is overwritten.
// - returned message control shows flags before the read cleared them.
// - identifier shows highest priority: status first, then lowest object number.
// - message interrupt clears by pending clear or status read; status by read.
// - identifier reads 0x0000 when nothing pends, nonzero means pending.
// - irq line is enable and nonzero identifier; identifier updates regardless.
// - rx/tx ok and error code need status enable; bus off and warning need error enable.
// - identifier reads 0x8000 after any enabled ok or error code update, changed or not; bus off and warning only on a change.
// - status write loads ok flags and error code from the written data, never the status source.
// - pending map shows each object's interrupt_pending_flag.
// - read with clear_pending_on_read clears pending; identifier moves to next.
// - object 1 has highest priority for reception and transmit requests.
// - storing into an object with new data already set sets message_lost_flag.
module crx_handler
	import crx_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [5:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic rx_frame,
	input wire logic [28:0] rx_id,
	input wire logic rx_xtd,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	input wire logic st_rx_ok,
	input wire logic st_tx_ok,
	input wire logic st_lec_upd,
	input wire logic [2:0] st_lec,
	input wire logic st_bus_off_flag,
	input wire logic st_warn,
	output logic tx_req,
	output logic [5:0] tx_req_obj,
	output logic [28:0] tx_req_id,
	output logic tx_req_xtd,
	input wire logic tx_done,
	output logic irq
);
	// object storage
	logic [28:0] o_id [NOBJ];
	logic [28:0] o_msk [NOBJ];
	logic [3:0] o_dlc [NOBJ];
	logic [63:0] o_dat [NOBJ];
	logic [NOBJ-1:0] o_val, o_xtd, o_um, o_rxie, o_eob;
	logic [NOBJ-1:0] o_nd, o_ml, o_ip, o_tr;
	// interface buffer and control state
	logic [7:0] cmsk;
	logic [28:0] b_msk;
	logic [31:0] b_arb;
	logic [15:0] b_mctl;
	logic [31:0] b_da, b_db;
	logic ctl_ie, ctl_sie, ctl_eie;
	logic [2:0] s_lec;
	logic s_tx_ok_flag, s_rx_ok_flag, s_bus_off_flag, s_warn, status_pend;
	// held received frame
	logic h_vld, h_xtd;
	logic [28:0] h_id;
	logic [3:0] h_dlc;
	logic [63:0] h_dat;
	// derived
	logic [NOBJ-1:0] hit, cand;
	logic [5:0] st_num, ip_num, tr_num, cmd_num;
	logic [4:0] si, ci, ti;
	logic cmd_go, cmd_rd, cmd_wr, do_store, sts_rd, ev_sts, sel_nd, sel_ip;
	logic [15:0] int_id;

	// command request decode
	assign cmd_num = wdata[5:0];
	assign cmd_go = wr_en && addr == A_CRQ && cmd_num != 6'h00 && cmd_num <= 6'(NOBJ);
	assign cmd_rd = cmd_go && !cmsk[CM_WRNRD];
	assign cmd_wr = cmd_go && cmsk[CM_WRNRD];
	assign ci = 5'(cmd_num - 6'h01);
	assign sel_nd = o_nd[ci];
	assign sel_ip = o_ip[ci];
	assign sts_rd = rd_en && addr == A_STS;

	// per-object acceptance and fifo lock test
	for (genvar i = 0; i < NOBJ; i++) begin : g_obj
		assign hit[i] = o_val[i] && o_xtd[i] == h_xtd
			&& ((o_id[i] ^ h_id) & (o_um[i] ? o_msk[i] : '1)) == 29'h0;
		assign cand[i] = hit[i] && !(o_nd[i] && !o_eob[i]);
	end

	// lowest free matching object takes the message
	crx_prio_enc u_store (
		.req(cand),
		.num(st_num)
	);
	// lowest pending interrupt names the identifier
	crx_prio_enc u_int (
		.req(o_ip),
		.num(ip_num)
	);
	// lowest pending remote request goes out first
	crx_prio_enc u_tx (
		.req(o_tr),
		.num(tr_num)
	);
	assign si = 5'(st_num - 6'h01);
	assign ti = 5'(tx_req_obj - 6'h01);
	// stores wait while a command transfer owns the storage
	assign do_store = h_vld && !cmd_go && st_num != 6'h00;

	// status first, else object number 1..32, else zero
	always_comb begin
		if (status_pend) begin
			int_id = ID_STATUS;
		end else begin
			int_id = {10'h000, ip_num};
		end
	end

	// frame holding register between the core and the handler
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			h_vld <= 1'b0;
			h_xtd <= 1'b0;
			h_id <= 29'h0;
			h_dlc <= 4'h0;
			h_dat <= 64'h0;
		end else if (rx_frame) begin
			h_vld <= 1'b1;
			h_xtd <= rx_xtd;
			h_id <= rx_id;
			h_dlc <= rx_dlc;
			h_dat <= rx_data;
		end else if (!cmd_go) begin
			h_vld <= 1'b0; // stored, or no free object matched
		end
	end

	// object payload storage, written by stores and command writes
	always_ff @(posedge clk) begin
		if (do_store) begin
			o_id[si] <= h_id;
			o_dlc[si] <= h_dlc;
			o_dat[si] <= h_dat;
		end
		if (cmd_wr && cmsk[CM_ARB]) begin
			o_id[ci] <= b_arb[28:0];
		end
		if (cmd_wr && cmsk[CM_MASK]) begin
			o_msk[ci] <= b_msk;
		end
		if (cmd_wr && cmsk[CM_CTRL]) begin
			o_dlc[ci] <= b_mctl[3:0];
		end
		if (cmd_wr && cmsk[CM_DA]) begin
			o_dat[ci][31:0] <= b_da;
		end
		if (cmd_wr && cmsk[CM_DB]) begin
			o_dat[ci][63:32] <= b_db;
		end
	end

	// object configuration bits
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			o_val <= '0;
			o_xtd <= '0;
			o_um <= '0;
			o_rxie <= '0;
			o_eob <= '0;
		end else if (cmd_wr) begin
			if (cmsk[CM_ARB]) begin
				o_val[ci] <= b_arb[ARB_VAL];
				o_xtd[ci] <= b_arb[ARB_XTD];
			end
			if (cmsk[CM_CTRL]) begin
				o_um[ci] <= b_mctl[MC_UM];
				o_rxie[ci] <= b_mctl[MC_RXIE];
				o_eob[ci] <= b_mctl[MC_EOB];
			end
		end
	end

	// object flags; later assignments win, so hardware sets beat clears
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			o_nd <= '0;
			o_ml <= '0;
			o_ip <= '0;
			o_tr <= '0;
		end else begin
			if (sts_rd) begin
				o_ip <= '0;
			end
			if (tx_done && tx_req_obj != 6'h00) begin
				o_tr[ti] <= 1'b0;
			end
			if (cmd_rd) begin
				if (cmsk[CM_NDTR]) begin
					o_nd[ci] <= 1'b0;
				end
				if (cmsk[CM_CLRP]) begin
					o_ip[ci] <= 1'b0;
				end
			end
			if (cmd_wr && cmsk[CM_CTRL]) begin
				o_nd[ci] <= b_mctl[MC_ND];
				o_ml[ci] <= b_mctl[MC_ML]; // software clears lost flag
				o_ip[ci] <= b_mctl[MC_IP];
				o_tr[ci] <= b_mctl[MC_TR];
			end
			if (cmd_wr && cmsk[CM_NDTR]) begin
				o_tr[ci] <= 1'b1;
			end
			if (do_store) begin
				o_nd[si] <= 1'b1;
				o_ml[si] <= o_ml[si] | o_nd[si];
				o_ip[si] <= o_ip[si] | o_rxie[si];
				o_tr[si] <= 1'b0;
			end
		end
	end

	// interface buffer registers, filled by software or by a command read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmsk <= CMSK_RST;
			b_msk <= 29'h0;
			b_arb <= 32'h0;
			b_mctl <= 16'h0;
			b_da <= 32'h0;
			b_db <= 32'h0;
		end else if (cmd_rd) begin
			if (cmsk[CM_MASK]) begin
				b_msk <= o_msk[ci];
			end
			if (cmsk[CM_ARB]) begin
				b_arb <= {o_val[ci], o_xtd[ci], 1'b0, o_id[ci]};
			end
			if (cmsk[CM_CTRL]) begin
				// flags as they stood before this read cleared them
				b_mctl <= {sel_nd, o_ml[ci], sel_ip, o_um[ci], 1'b0, o_rxie[ci], 1'b0,
					o_tr[ci], o_eob[ci], 3'h0, o_dlc[ci]};
			end
			if (cmsk[CM_DA]) begin
				b_da <= o_dat[ci][31:0];
			end
			if (cmsk[CM_DB]) begin
				b_db <= o_dat[ci][63:32];
			end
		end else if (wr_en) begin
			unique case (addr)
				A_CMSK: cmsk <= wdata[7:0];
				A_MSK: b_msk <= wdata[28:0];
				A_ARB: b_arb <= {wdata[31:30], 1'b0, wdata[28:0]};
				A_MCTL: b_mctl <= wdata[15:0] & 16'hF58F;
				A_DA: b_da <= wdata;
				A_DB: b_db <= wdata;
				default: ;
			endcase
		end
	end

	// control register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_ie <= 1'b0;
			ctl_sie <= 1'b0;
			ctl_eie <= 1'b0;
		end else if (wr_en && addr == A_CTL) begin
			ctl_ie <= wdata[CTL_IE];
			ctl_sie <= wdata[CTL_SIE];
			ctl_eie <= wdata[CTL_EIE];
		end
	end

	// enabled status event: ok or error code update, or bus off / warning change
	assign ev_sts = (ctl_sie && (st_rx_ok || st_tx_ok || st_lec_upd))
		|| (ctl_eie && (st_bus_off_flag != s_bus_off_flag || st_warn != s_warn));

	// status register; core updates beat a software write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_lec <= 3'h0;
			s_tx_ok_flag <= 1'b0;
			s_rx_ok_flag <= 1'b0;
			s_bus_off_flag <= 1'b0;
			s_warn <= 1'b0;
		end else begin
			s_bus_off_flag <= st_bus_off_flag;
			s_warn <= st_warn;
			if (wr_en && addr == A_STS) begin
				s_lec <= wdata[2:0];
				s_tx_ok_flag <= wdata[STS_TX_OK_FLAG];
				s_rx_ok_flag <= wdata[STS_RX_OK_FLAG];
			end
			if (st_lec_upd) begin
				s_lec <= st_lec;
			end
			if (st_tx_ok) begin
				s_tx_ok_flag <= 1'b1;
			end
			if (st_rx_ok) begin
				s_rx_ok_flag <= 1'b1;
			end
		end
	end

	// status interrupt source; only a status read clears it, a new event wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_pend <= 1'b0;
		end else if (ev_sts) begin
			status_pend <= 1'b1;
		end else if (sts_rd) begin
			status_pend <= 1'b0;
		end
	end

	// interrupt line from a flop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= ctl_ie && int_id != ID_NONE;
		end
	end

	// remote frame request toward the core
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_req <= 1'b0;
			tx_req_obj <= 6'h00;
			tx_req_id <= 29'h0;
			tx_req_xtd <= 1'b0;
		end else begin
			tx_req <= tr_num != 6'h00 && !(tx_done && tr_num == tx_req_obj);
			tx_req_obj <= tr_num;
			// idle request shows zeros; the unreset identifier store must not leak out
			tx_req_id <= (tr_num != 6'h00) ? o_id[5'(tr_num - 6'h01)] : 29'h0;
			tx_req_xtd <= (tr_num != 6'h00) ? o_xtd[5'(tr_num - 6'h01)] : 1'b0;
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 32'h0;
		end else if (!rd_en) begin
			rdata <= 32'h0;
		end else begin
			unique case (addr)
				A_CTL: rdata <= {28'h0, ctl_eie, ctl_sie, ctl_ie, 1'b0};
				A_STS: rdata <= {24'h0, s_bus_off_flag, s_warn, 1'b0, s_rx_ok_flag, s_tx_ok_flag, s_lec};
				A_INT: rdata <= {16'h0, int_id};
				A_CMSK: rdata <= {24'h0, cmsk};
				A_MSK: rdata <= {3'h0, b_msk};
				A_ARB: rdata <= b_arb;
				A_MCTL: rdata <= {16'h0, b_mctl};
				A_DA: rdata <= b_da;
				A_DB: rdata <= b_db;
				A_PMAP: rdata <= o_ip;
				default: rdata <= 32'h0;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_irq_raise: assert property ((ctl_ie && int_id != ID_NONE) |=> irq)
		else $error("irq not raised for pending id");
	a_irq_drop: assert property ((!ctl_ie || int_id == ID_NONE) |=> !irq)
		else $error("irq active without cause");
	a_status_id: assert property (status_pend |-> int_id == ID_STATUS)
		else $error("status pending but id not 0x8000");
	a_status_set: assert property (ev_sts |=> status_pend ##0 int_id == ID_STATUS)
		else $error("enabled status event lost");
	a_status_gate: assert property ((!status_pend && !ctl_sie && !ctl_eie) |=> !status_pend)
		else $error("status interrupt with enables clear");
	a_sts_rd_clr: assert property ((sts_rd && !ev_sts)
		|=> !status_pend && ($past(do_store) || o_ip == '0))
		else $error("status read left a source pending");
	a_sts_wr_keep: assert property ((wr_en && addr == A_STS && status_pend) |=> status_pend)
		else $error("status write cleared the source");
	a_id_zero: assert property ((!status_pend && o_ip == '0) |-> int_id == ID_NONE)
		else $error("id nonzero with nothing pending");
	a_store_nd: assert property (do_store |=> o_nd[$past(si)] && !o_tr[$past(si)])
		else $error("stored object lacks new data");
	a_msg_lost: assert property ((do_store && o_nd[si]) |=> o_ml[$past(si)])
		else $error("overrun did not set lost flag");
	a_lock_kept: assert property (do_store |-> !(o_nd[si] && !o_eob[si]))
		else $error("locked fifo object overwritten");
	a_rd_clrp: assert property ((cmd_rd && cmsk[CM_CLRP]) |=> !o_ip[$past(ci)])
		else $error("read did not clear pending");
	a_mctl_prior: assert property ((cmd_rd && cmsk[CM_CTRL])
		|=> b_mctl[MC_ND] == $past(sel_nd) && b_mctl[MC_IP] == $past(sel_ip))
		else $error("message control not pre-clear value");
endmodule

// ===== crx_core_model.sv
// crx_core_model: can core and far nodes as seen by the receive message handler.
// assumes the handler's clock; the bench calls its tasks to send frames and status.
`timescale 1ns/100ps
module crx_core_model (
	input wire logic clk,
	output logic rx_frame,
	output logic [28:0] rx_id,
	output logic rx_xtd,
	output logic [3:0] rx_dlc,
	output logic [63:0] rx_data,
	output logic st_rx_ok,
	output logic st_tx_ok,
	output logic st_lec_upd,
	output logic [2:0] st_lec,
	output logic st_bus_off_flag,
	output logic st_warn,
	input wire logic tx_req,
	input wire logic [5:0] tx_req_obj,
	output logic tx_done
);
	int tx_delay = 0;
	bit tx_hold = 1'b0;
	int wait_cnt = 0;
	logic [5:0] sent_q[$];
	// quiet lines at time zero
	initial begin
		{rx_frame, rx_xtd, st_rx_ok, st_tx_ok, st_lec_upd, st_bus_off_flag, st_warn, tx_done} = '0;
		{rx_id, rx_dlc, rx_data, st_lec} = '0;
	end
	// one data frame for one cycle, payload lines scrambled once it is gone
	task automatic send_frame(input logic [28:0] id, input logic [63:0] d);
		@(posedge clk);
		rx_frame <= 1'b1;
		rx_id <= id;
		rx_xtd <= 1'b1;
		rx_dlc <= 4'h8;
		rx_data <= d;
		@(posedge clk);
		rx_frame <= 1'b0;
		rx_id <= ~id;
		rx_data <= ~d;
	endtask
	// status update pulses, error code always reported as 3
	task automatic pulse_status(input logic rx, input logic tx);
		@(posedge clk);
		st_rx_ok <= rx;
		st_tx_ok <= tx;
		st_lec_upd <= 1'b1;
		st_lec <= 3'h3;
		@(posedge clk);
		{st_rx_ok, st_tx_ok, st_lec_upd} <= 3'h0;
	endtask
	task automatic set_warn(input logic v);
		@(posedge clk);
		st_warn <= v;
	endtask
	task automatic set_bus_off_flag(input logic v);
		@(posedge clk);
		st_bus_off_flag <= v;
	endtask
	// sends the offered remote frame after tx_delay cycles unless held back
	always @(posedge clk) begin
		tx_done <= 1'b0;
		if (wait_cnt < 0) begin
			wait_cnt <= wait_cnt + 1;
		end else if (tx_req && !tx_hold) begin
			if (wait_cnt >= tx_delay) begin
				tx_done <= 1'b1;
				sent_q.push_back(tx_req_obj);
				wait_cnt <= -3;
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule

// ===== crx_handler_tb_top.sv
// crx_handler_tb_top: self-checking bench of the receive message handler.
// assumes crx_pkg, crx_handler and crx_core_model are compiled before it.
`timescale 1ns/100ps
module crx_handler_tb_top
	import crx_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] addr = '0;
	logic [31:0] wdata = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rdata;
	logic rx_frame, rx_xtd, st_rx_ok, st_tx_ok, st_lec_upd, st_bus_off_flag, st_warn, tx_done;
	logic [28:0] rx_id, tx_req_id;
	logic [3:0] rx_dlc;
	logic [63:0] rx_data;
	logic [2:0] st_lec;
	logic tx_req, tx_req_xtd, irq;
	logic [5:0] tx_req_obj;
	int fails = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h17;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	crx_handler DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .rx_frame(rx_frame), .rx_id(rx_id), .rx_xtd(rx_xtd),
		.rx_dlc(rx_dlc), .rx_data(rx_data), .st_rx_ok(st_rx_ok), .st_tx_ok(st_tx_ok),
		.st_lec_upd(st_lec_upd), .st_lec(st_lec), .st_bus_off_flag(st_bus_off_flag), .st_warn(st_warn),
		.tx_req(tx_req), .tx_req_obj(tx_req_obj), .tx_req_id(tx_req_id),
		.tx_req_xtd(tx_req_xtd), .tx_done(tx_done), .irq(irq));
	crx_core_model core (.clk(clk), .rx_frame(rx_frame), .rx_id(rx_id), .rx_xtd(rx_xtd),
		.rx_dlc(rx_dlc), .rx_data(rx_data), .st_rx_ok(st_rx_ok), .st_tx_ok(st_tx_ok),
		.st_lec_upd(st_lec_upd), .st_lec(st_lec), .st_bus_off_flag(st_bus_off_flag), .st_warn(st_warn),
		.tx_req(tx_req), .tx_req_obj(tx_req_obj), .tx_done(tx_done));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected message control: flags nd ml ip um ie eob in f[5:0], length 8
	function automatic logic [31:0] mc(input logic [5:0] f);
		return {16'h0, f[5:2], 1'b0, f[1], 2'h0, f[0], 3'h0, 4'h8};
	endfunction
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// register port: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic cfg(input logic [5:0] n, input logic [28:0] id, input logic [28:0] m,
		input logic [5:0] f);
		wr(A_MSK, {3'h0, m});
		wr(A_ARB, {2'h3, 1'b0, id});
		wr(A_MCTL, mc(f));
		wr(A_CMSK, 32'hF0);
		wr(A_CRQ, {26'h0, n});
	endtask
	// read a whole object, clearing new data and pending
	task automatic pull(input logic [5:0] n);
		wr(A_CMSK, {24'h0, CMSK_READ_ALL});
		wr(A_CRQ, {26'h0, n});
	endtask
	// cut a hang short
	initial begin
		#(25 * 20000);
		fails++;
		stop_test();
	end
	// main sequence
	initial begin
		logic [28:0] ida, idm, idf, idr, idq;
		logic [63:0] d1, d2, d3;
		logic [31:0] v;
		ida = 29'(rnd());
		idf = ida ^ 29'h10000000;
		idr = ida ^ 29'h08000000;
		idq = ida ^ 29'h04000000;
		d1 = {rnd(), rnd()};
		d2 = {rnd(), rnd()};
		d3 = {rnd(), rnd()};
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rdc(A_INT, 32'h0);
		rdc(6'h3C, 32'h0);
		wr(A_CTL, 32'h2);
		cfg(6'h3, ida, 29'h1FFFFF00, 6'h07);
		cfg(6'h5, idf, 29'h0, 6'h02);
		cfg(6'h6, idf, 29'h0, 6'h03);
		cfg(6'h7, idr, 29'h0, 6'h01);
		cfg(6'h4, idq, 29'h0, 6'h01);
		// three frames into a two-entry fifo, then two later ones for a lower object
		core.send_frame(idf, d1);
		idle(3);
		core.send_frame(idf, d2);
		idle(3);
		core.send_frame(idf, d3);
		idle(3);
		rdc(A_PMAP, 32'h30);
		rdc(A_INT, 32'h5);
		chk({31'h0, irq}, 32'h1);
		v = rnd();
		idm = ida ^ {21'h0, v[7:0]};
		core.send_frame(idm, d1);
		idle(3);
		core.send_frame(idm, d2);
		idle(3);
		rdc(A_INT, 32'h3);
		pull(6'h3);
		rdc(A_MCTL, mc(6'h3F));
		rdc(A_MSK, 32'h1FFFFF00);
		rdc(A_ARB, {2'h3, 1'b0, idm});
		rdc(A_DA, d2[31:0]);
		rdc(A_DB, d2[63:32]);
		rdc(A_INT, 32'h5);
		pull(6'h3);
		rdc(A_MCTL, mc(6'h17));
		// fifo emptied from the lowest object
		pull(6'h5);
		rdc(A_MCTL, mc(6'h2A));
		rdc(A_DA, d1[31:0]);
		pull(6'h6);
		rdc(A_MCTL, mc(6'h3B));
		rdc(A_DB, d3[63:32]);
		rdc(A_INT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// enable off: line quiet, identifier still live
		core.send_frame(idm, d3);
		idle(3);
		wr(A_CTL, 32'h0);
		idle(2);
		chk({31'h0, irq}, 32'h0);
		rdc(A_INT, 32'h3);
		// status interrupt over a pending object
		wr(A_CTL, 32'h6);
		core.pulse_status(1'b1, 1'b0);
		idle(2);
		rdc(A_INT, {16'h0, ID_STATUS});
		wr(A_STS, 32'h0);
		rdc(A_INT, {16'h0, ID_STATUS});
		rdc(A_STS, 32'h0);
		rdc(A_INT, 32'h0);
		rdc(A_PMAP, 32'h0);
		core.pulse_status(1'b1, 1'b0);
		rdc(A_STS, 32'h13);
		core.pulse_status(1'b1, 1'b0);
		idle(2);
		rdc(A_INT, {16'h0, ID_STATUS});
		rdc(A_STS, 32'h13);
		wr(A_CTL, 32'hA);
		core.pulse_status(1'b1, 1'b1);
		idle(2);
		rdc(A_INT, 32'h0);
		core.set_warn(1'b1);
		idle(2);
		rdc(A_INT, {16'h0, ID_STATUS});
		rdc(A_STS, 32'h5B);
		rdc(A_INT, 32'h0);
		// bus off change under the error enable
		core.set_bus_off_flag(1'b1);
		idle(2);
		rdc(A_INT, {16'h0, ID_STATUS});
		rdc(A_STS, 32'hDB);
		// remote requests: identifier, order by object number, early data frame
		core.tx_hold <= 1'b1;
		wr(A_CMSK, 32'h84);
		wr(A_CRQ, 32'h7);
		idle(3);
		chk({26'h0, tx_req_obj}, 32'h7);
		chk({2'h0, tx_req_xtd, tx_req_id}, {2'h0, 1'b1, idr});
		wr(A_CMSK, 32'h84);
		wr(A_CRQ, 32'h4);
		idle(3);
		chk({26'h0, tx_req_obj}, 32'h4);
		core.tx_delay <= 5;
		core.tx_hold <= 1'b0;
		idle(40);
		chk({31'h0, tx_req}, 32'h0);
		chk({20'h0, core.sent_q[0], core.sent_q[1]}, {20'h0, 6'h4, 6'h7});
		core.tx_hold <= 1'b1;
		wr(A_CMSK, 32'h84);
		wr(A_CRQ, 32'h7);
		idle(3);
		chk({31'h0, tx_req}, 32'h1);
		core.send_frame(idr, d1);
		idle(3);
		chk({31'h0, tx_req}, 32'h0);
		// random identifiers under the mask
		repeat (4) begin
			v = rnd();
			idm = ida ^ {21'h0, v[7:0]};
			d1 = {rnd(), v};
			core.send_frame(idm, d1);
			idle(3);
			pull(6'h3);
			rdc(A_ARB, {2'h3, 1'b0, idm});
			rdc(A_DA, d1[31:0]);
		end
		stop_test();
	end
endmodule
